// ---- adcc_top.sv ----
module adcc_top (
   input logic aclk,
   input logic aresetn,
   input logic [11:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input logic [11:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   input logic [5:0] timer_reg_events,
   input logic reg_ext_line,
   input logic [5:0] timer_inj_events,
   input logic inj_ext_line,
   input logic watchdog_event,
   input logic [11:0] adc_sample,
   output logic [4:0] adc_channel,
   output logic adc_busy,
   output logic temp_vref_power,
   output logic dma_req,
   output logic irq
);
   adcc_conv_if cv ();
   logic aw_have_q, w_have_q, wr_commit, rd_err;
   logic [11:0] aw_addr_q, wsel, rsel;
   logic [31:0] w_data_q, wmask, rd_data;
   logic [3:0] w_strb_q;
   logic [6:0] sts_q, sts_d, sts_set, sts_clr, ien;
   logic [31:0] ctrl1_q, ctrl2_q, sampt1_q, sampt2_q, chsel_q;
   logic [11:0] dat_q;
   logic rsw_q, jsw_q, on_prev_q, rtrig, jtrig;
   logic [2:0] samp_sel [32];

   function automatic logic [31:0] upd(input logic [31:0] old, input logic [31:0] wd,
                                       input logic [31:0] m);
      return (old & ~m) | (wd & m);
   endfunction

   // ****************************************************
   // AXI4-Lite write path
   // ****************************************************
   assign wr_commit = aw_have_q & w_have_q & ~bvalid;
   assign wsel = {aw_addr_q[11:2], 2'b00};
   assign rsel = {araddr[11:2], 2'b00};

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i+:8] = {8{w_strb_q[i]}};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (wr_commit) begin
         awready <= 1'b1;
         aw_have_q <= 1'b0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_have_q <= 1'b1;
         aw_addr_q <= awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_have_q <= 1'b0;
         w_data_q <= adcc_pkg::RST_ZERO;
         w_strb_q <= 4'h0;
      end else if (wr_commit) begin
         wready <= 1'b1;
         w_have_q <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_have_q <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= adcc_pkg::RESP_OKAY;
      end else if (wr_commit) begin
         bvalid <= 1'b1;
         case (wsel)
            adcc_pkg::OFS_STS, adcc_pkg::OFS_CTRL1, adcc_pkg::OFS_CTRL2,
            adcc_pkg::OFS_SAMPT1, adcc_pkg::OFS_SAMPT2, adcc_pkg::OFS_CHSEL,
            adcc_pkg::OFS_DAT: bresp <= adcc_pkg::RESP_OKAY;
            default: bresp <= adcc_pkg::RESP_SLVERR;
         endcase
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ****************************************************
   // Control registers
   // ****************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl1_q <= adcc_pkg::RST_ZERO;
         ctrl2_q <= adcc_pkg::RST_ZERO;
         sampt1_q <= adcc_pkg::RST_ZERO;
         sampt2_q <= adcc_pkg::RST_ZERO;
         chsel_q <= adcc_pkg::RST_ZERO;
      end else if (wr_commit) begin
         if (wsel == adcc_pkg::OFS_CTRL1) begin
            ctrl1_q <= upd(ctrl1_q, w_data_q, wmask & adcc_pkg::MASK_CTRL1);
         end
         if (wsel == adcc_pkg::OFS_CTRL2) begin
            ctrl2_q <= upd(ctrl2_q, w_data_q, wmask & adcc_pkg::MASK_CTRL2);
         end
         if (wsel == adcc_pkg::OFS_SAMPT1) begin
            sampt1_q <= upd(sampt1_q, w_data_q, wmask & adcc_pkg::MASK_SAMPT1);
         end
         if (wsel == adcc_pkg::OFS_SAMPT2) begin
            sampt2_q <= upd(sampt2_q, w_data_q, wmask & adcc_pkg::MASK_SAMPT2);
         end
         if (wsel == adcc_pkg::OFS_CHSEL) begin
            chsel_q <= upd(chsel_q, w_data_q, wmask & adcc_pkg::MASK_CHSEL);
         end
      end
   end

   // Soft start bits are not stored; a write of one gives a single pulse.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsw_q <= 1'b0;
         jsw_q <= 1'b0;
         on_prev_q <= 1'b0;
      end else begin
         rsw_q <= wr_commit && (wsel == adcc_pkg::OFS_CTRL2)
                  && wmask[adcc_pkg::C2_RSW] && w_data_q[adcc_pkg::C2_RSW];
         jsw_q <= wr_commit && (wsel == adcc_pkg::OFS_CTRL2)
                  && wmask[adcc_pkg::C2_JSW] && w_data_q[adcc_pkg::C2_JSW];
         on_prev_q <= ctrl2_q[adcc_pkg::C2_ON];
      end
   end

   // ****************************************************
   // Triggers and conversion engine
   // ****************************************************
   // selector per channel
   for (genvar c = 0; c < 32; c++) begin : g_samp
      if (c < adcc_pkg::SAMPT1_FIRST) begin : g_lo
         assign samp_sel[c] = sampt2_q[3*c+:3];
      end else if (c < adcc_pkg::NUM_CH) begin : g_hi
         assign samp_sel[c] = sampt1_q[3*(c-adcc_pkg::SAMPT1_FIRST)+:3];
      end else begin : g_none
         assign samp_sel[c] = 3'h0;
      end
   end

   adcc_trig u_rtrig (
      .aclk(aclk),
      .aresetn(aresetn),
      .events(timer_reg_events),
      .ext_line(reg_ext_line),
      .sw_start(rsw_q),
      .sel(ctrl2_q[adcc_pkg::C2_RSEL+:3]),
      .ext_en(ctrl2_q[adcc_pkg::C2_REXT]),
      .trig(rtrig)
   );

   adcc_trig u_jtrig (
      .aclk(aclk),
      .aresetn(aresetn),
      .events(timer_inj_events),
      .ext_line(inj_ext_line),
      .sw_start(jsw_q),
      .sel(ctrl2_q[adcc_pkg::C2_JSEL+:3]),
      .ext_en(ctrl2_q[adcc_pkg::C2_JEXT]),
      .trig(jtrig)
   );

   assign cv.enable = ctrl2_q[adcc_pkg::C2_ON];
   assign cv.start_reg = (ctrl2_q[adcc_pkg::C2_ON] & ~on_prev_q) | rtrig;
   assign cv.start_inj = jtrig;
   assign cv.cyc_reg = adcc_pkg::conv_cycles(samp_sel[chsel_q[adcc_pkg::CH_REG+:5]]);
   assign cv.cyc_inj = adcc_pkg::conv_cycles(samp_sel[chsel_q[adcc_pkg::CH_INJ+:5]]);

   adcc_conv u_conv (
      .aclk(aclk),
      .aresetn(aresetn),
      .cv(cv)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dat_q <= 12'h000;
      end else if (cv.reg_end || cv.inj_end) begin
         dat_q <= adc_sample;
      end
   end

   // ****************************************************
   // Status flags and outputs
   // ****************************************************
   always_comb begin
      sts_set = 7'h00;
      sts_set[adcc_pkg::ST_WD] = watchdog_event;
      sts_set[adcc_pkg::ST_SEQ] = cv.reg_end | cv.inj_end;
      sts_set[adcc_pkg::ST_INJ] = cv.inj_end;
      sts_set[adcc_pkg::ST_JSTART] = cv.inj_begin;
      sts_set[adcc_pkg::ST_RSTART] = cv.reg_begin;
      sts_set[adcc_pkg::ST_RCH] = cv.reg_end;
      sts_set[adcc_pkg::ST_JCH] = cv.inj_end;
      sts_clr = 7'h00;
      if (wr_commit && wsel == adcc_pkg::OFS_STS) begin
         sts_clr = wmask[6:0] & ~w_data_q[6:0];
      end
      sts_d = (sts_q & ~sts_clr) | sts_set;
      ien = 7'h00;
      ien[adcc_pkg::ST_WD] = ctrl1_q[adcc_pkg::IE_WD];
      ien[adcc_pkg::ST_SEQ] = ctrl1_q[adcc_pkg::IE_SEQ];
      ien[adcc_pkg::ST_INJ] = ctrl1_q[adcc_pkg::IE_INJ];
      ien[adcc_pkg::ST_RCH] = ctrl1_q[adcc_pkg::IE_RCH];
      ien[adcc_pkg::ST_JCH] = ctrl1_q[adcc_pkg::IE_JCH];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sts_q <= 7'h00;
         irq <= 1'b0;
      end else begin
         sts_q <= sts_d;
         irq <= |(sts_d & ien);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_req <= 1'b0;
         temp_vref_power <= 1'b0;
         adc_channel <= 5'h00;
         adc_busy <= 1'b0;
      end else begin
         dma_req <= ctrl2_q[adcc_pkg::C2_DMA] & cv.reg_end;
         temp_vref_power <= ctrl2_q[adcc_pkg::C2_TEMP];
         adc_channel <= cv.inj_active ? chsel_q[adcc_pkg::CH_INJ+:5]
                                      : chsel_q[adcc_pkg::CH_REG+:5];
         adc_busy <= cv.busy;
      end
   end

   // ****************************************************
   // AXI4-Lite read path
   // ****************************************************
   always_comb begin
      rd_data = adcc_pkg::RST_ZERO;
      rd_err = 1'b0;
      case (rsel)
         adcc_pkg::OFS_STS: rd_data = {25'h0, sts_q};
         adcc_pkg::OFS_CTRL1: rd_data = ctrl1_q;
         adcc_pkg::OFS_CTRL2: rd_data = ctrl2_q;
         adcc_pkg::OFS_SAMPT1: rd_data = sampt1_q;
         adcc_pkg::OFS_SAMPT2: rd_data = sampt2_q;
         adcc_pkg::OFS_CHSEL: rd_data = chsel_q;
         adcc_pkg::OFS_DAT: rd_data = {20'h0, dat_q};
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= adcc_pkg::RST_ZERO;
         rresp <= adcc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_data;
         rresp <= rd_err ? adcc_pkg::RESP_SLVERR : adcc_pkg::RESP_OKAY;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   AST_DMA_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
      cv.reg_end |=> dma_req == $past(ctrl2_q[adcc_pkg::C2_DMA]))
      else $error("dma request does not follow regular end");
   AST_STARTED_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
      (sts_q & ien) == 7'h00 && sts_set == 7'h00 |=> !irq)
      else $error("started flags raised an interrupt");
   AST_SEQ_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
      cv.inj_end |=> sts_q[adcc_pkg::ST_SEQ] && sts_q[adcc_pkg::ST_INJ] && sts_q[adcc_pkg::ST_JCH])
      else $error("injected end did not set its flags");
   AST_WD_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_event && ctrl1_q[adcc_pkg::IE_WD] |=> irq && sts_q[adcc_pkg::ST_WD])
      else $error("enabled watchdog event gave no interrupt");
   AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      sts_q[adcc_pkg::ST_RCH] && !(wr_commit && wsel == adcc_pkg::OFS_STS)
      |=> sts_q[adcc_pkg::ST_RCH])
      else $error("flag dropped without software clear");
   AST_ON_START: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ctrl2_q[adcc_pkg::C2_ON]) && !cv.busy |=> cv.reg_begin || cv.inj_begin)
      else $error("power-on did not start a conversion");
   AST_TEMP_PWR: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 temp_vref_power == $past(ctrl2_q[adcc_pkg::C2_TEMP]))
      else $error("temperature power does not follow enable");
endmodule

// ---- adcc_pkg.sv ----
package adcc_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [11:0] OFS_STS = 12'h000;
   localparam logic [11:0] OFS_CTRL1 = 12'h004;
   localparam logic [11:0] OFS_CTRL2 = 12'h008;
   localparam logic [11:0] OFS_SAMPT1 = 12'h00C;
   localparam logic [11:0] OFS_SAMPT2 = 12'h010;
   localparam logic [11:0] OFS_CHSEL = 12'h024;
   localparam logic [11:0] OFS_DAT = 12'h04C;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] MASK_CTRL1 = 32'h0300_00E0;
   localparam logic [31:0] MASK_CTRL2 = 32'h009E_F101;
   localparam logic [31:0] MASK_SAMPT1 = 32'h00FF_FFFF;
   localparam logic [31:0] MASK_SAMPT2 = 32'h3FFF_FFFF;
   localparam logic [31:0] MASK_CHSEL = 32'h0000_1F1F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int ST_WD = 0;
   localparam int ST_SEQ = 1;
   localparam int ST_INJ = 2;
   localparam int ST_JSTART = 3;
   localparam int ST_RSTART = 4;
   localparam int ST_RCH = 5;
   localparam int ST_JCH = 6;
   localparam int IE_SEQ = 5;
   localparam int IE_WD = 6;
   localparam int IE_INJ = 7;
   localparam int IE_RCH = 24;
   localparam int IE_JCH = 25;
   localparam int C2_ON = 0;
   localparam int C2_DMA = 8;
   localparam int C2_JSEL = 12;
   localparam int C2_JEXT = 15;
   localparam int C2_RSEL = 17;
   localparam int C2_REXT = 20;
   localparam int C2_JSW = 21;
   localparam int C2_RSW = 22;
   localparam int C2_TEMP = 23;
   localparam int CH_REG = 0;
   localparam int CH_INJ = 8;
   localparam int NUM_CH = 18;
   localparam int SAMPT1_FIRST = 10;
   localparam logic [4:0] TEMP_CH = 5'h11;
   localparam logic [2:0] SEL_EXT_LINE = 3'h6;
   localparam logic [2:0] SEL_SOFT = 3'h7;
   // ****************************************************
   // Conversion timing in half converter cycles
   // ****************************************************
   localparam int FIXED_HALF = 25;
   localparam int SAMP_BASE_HALF = 3;
   localparam int SAMP_STEP_HALF = 16;
   function automatic logic [7:0] conv_cycles(input logic [2:0] code);
      return 8'((SAMP_BASE_HALF + SAMP_STEP_HALF * int'(code) + FIXED_HALF) / 2);
   endfunction
endpackage

// ---- adcc_conv_if.sv ----
interface adcc_conv_if;
   logic enable;
   logic start_reg;
   logic start_inj;
   logic [7:0] cyc_reg;
   logic [7:0] cyc_inj;
   logic reg_begin;
   logic inj_begin;
   logic reg_end;
   logic inj_end;
   logic busy;
   logic inj_active;
   modport ctl(output enable, start_reg, start_inj, cyc_reg, cyc_inj,
               input reg_begin, inj_begin, reg_end, inj_end, busy, inj_active);
   modport eng(input enable, start_reg, start_inj, cyc_reg, cyc_inj,
               output reg_begin, inj_begin, reg_end, inj_end, busy, inj_active);
endinterface

// ---- adcc_trig.sv ----
module adcc_trig (
   input logic aclk,
   input logic aresetn,
   input logic [5:0] events,
   input logic ext_line,
   input logic sw_start,
   input logic [2:0] sel,
   input logic ext_en,
   output logic trig
);
   logic src;
   logic prev_q;

   always_comb begin
      if (sel == adcc_pkg::SEL_SOFT) begin
         src = 1'b0;
      end else if (sel == adcc_pkg::SEL_EXT_LINE) begin
         src = ext_line;
      end else begin
         src = events[sel];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
         trig <= 1'b0;
      end else begin
         prev_q <= src;
         trig <= (ext_en & src & ~prev_q) | ((sel == adcc_pkg::SEL_SOFT) & sw_start);
      end
   end

   AST_SOFT_START: assert property (@(posedge aclk) disable iff (!aresetn)
      (sel == adcc_pkg::SEL_SOFT) && sw_start |=> trig)
      else $error("soft start did not trigger");
   AST_EXT_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
      ext_en && (sel != adcc_pkg::SEL_SOFT) && src && !$past(src) && $past(aresetn) |=> trig)
      else $error("rising trigger edge was missed");
endmodule

// ---- adcc_conv.sv ----
module adcc_conv (
   input logic aclk,
   input logic aresetn,
   adcc_conv_if.eng cv
);
   typedef enum logic {CV_IDLE, CV_RUN} adcc_cv_state_t;
   adcc_cv_state_t state_q;
   logic [7:0] cnt_q;
   logic inj_q;
   logic reg_pend_q;
   logic inj_pend_q;
   logic reg_begin_q, inj_begin_q, reg_end_q, inj_end_q;
   logic [7:0] el_q;
   logic [7:0] len_q;

   assign cv.reg_begin = reg_begin_q;
   assign cv.inj_begin = inj_begin_q;
   assign cv.reg_end = reg_end_q;
   assign cv.inj_end = inj_end_q;
   assign cv.busy = (state_q == CV_RUN);
   assign cv.inj_active = inj_q;

   // A second injected trigger during an injected conversion is dropped:
   // software must space injected triggers wider than one conversion.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= CV_IDLE;
         cnt_q <= 8'h00;
         inj_q <= 1'b0;
         reg_pend_q <= 1'b0;
         inj_pend_q <= 1'b0;
         reg_begin_q <= 1'b0;
         inj_begin_q <= 1'b0;
         reg_end_q <= 1'b0;
         inj_end_q <= 1'b0;
      end else begin
         reg_begin_q <= 1'b0;
         inj_begin_q <= 1'b0;
         reg_end_q <= 1'b0;
         inj_end_q <= 1'b0;
         if (!cv.enable) begin
            state_q <= CV_IDLE;
            inj_q <= 1'b0;
            reg_pend_q <= 1'b0;
            inj_pend_q <= 1'b0;
         end else begin
            unique case (state_q)
               CV_IDLE: begin
                  if (cv.start_inj || inj_pend_q) begin
                     state_q <= CV_RUN;
                     inj_q <= 1'b1;
                     cnt_q <= cv.cyc_inj;
                     inj_begin_q <= 1'b1;
                     inj_pend_q <= 1'b0;
                     reg_pend_q <= reg_pend_q | cv.start_reg;
                  end else if (cv.start_reg || reg_pend_q) begin
                     state_q <= CV_RUN;
                     inj_q <= 1'b0;
                     cnt_q <= cv.cyc_reg;
                     reg_begin_q <= 1'b1;
                     reg_pend_q <= 1'b0;
                  end
               end
               CV_RUN: begin
                  if (cv.start_inj && !inj_q) begin
                     inj_q <= 1'b1;
                     cnt_q <= cv.cyc_inj;
                     inj_begin_q <= 1'b1;
                     reg_pend_q <= 1'b1;
                  end else begin
                     if (cv.start_reg) begin
                        reg_pend_q <= 1'b1;
                     end
                     if (cnt_q <= 8'h01) begin
                        state_q <= CV_IDLE;
                        reg_end_q <= !inj_q;
                        inj_end_q <= inj_q;
                     end else begin
                        cnt_q <= cnt_q - 8'h01;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         el_q <= 8'h00;
         len_q <= 8'h00;
      end else if (reg_begin_q || inj_begin_q) begin
         el_q <= 8'h01;
         len_q <= cnt_q;
      end else if (state_q == CV_RUN) begin
         el_q <= el_q + 8'h01;
      end
   end

   AST_CONV_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
      (reg_end_q || inj_end_q) && cv.enable |-> el_q == len_q)
      else $error("conversion length differs from selected cycles");
   AST_INJ_PREEMPT: assert property (@(posedge aclk) disable iff (!aresetn)
      cv.enable && cv.busy && !inj_q && cv.start_inj |=> inj_q && inj_begin_q && reg_pend_q)
      else $error("injected trigger did not preempt regular conversion");
endmodule

// ---- adcc_far.sv ----
module adcc_far (
   input wire logic aclk,
   input wire logic go,
   input wire logic inj,
   input wire logic [2:0] code,
   input wire logic dma_req,
   output logic [6:0] rl,
   output logic [6:0] il,
   output int dma_n
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge aclk) begin
      rl <= (go && !inj) ? 7'h01 << code : 7'h00;
      il <= (go && inj) ? 7'h01 << code : 7'h00;
   end
   always @(posedge aclk) begin
      if (dma_req === 1'b1) begin
         dma_n <= dma_n + 1;
      end
   end
   initial begin
      rl = 7'h00;
      il = 7'h00;
   end
endmodule

// ---- tb_adc_trigger_dma_irq_control.sv ----
module tb_adc_trigger_dma_irq_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, inj, wde;
   logic awready, wready, bvalid, arready, rvalid, busy, tpw, dma_req, irq;
   logic [11:0] awaddr, araddr, smp;
   logic [31:0] wdata, rdata, rv, seed, c2;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rr;
   logic [4:0] ch;
   logic [2:0] code;
   logic [6:0] rl, il;
   int num_errors, num_checks, dma_n, k, nd;
   int q[$];
   adcc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .timer_reg_events(rl[5:0]), .reg_ext_line(rl[6]), .timer_inj_events(il[5:0]),
      .inj_ext_line(il[6]), .watchdog_event(wde), .adc_sample(smp), .adc_channel(ch),
      .adc_busy(busy), .temp_vref_power(tpw), .dma_req(dma_req), .irq(irq));
   adcc_far far_u (.aclk(aclk), .go(go), .inj(inj), .code(code), .dma_req(dma_req),
      .rl(rl), .il(il), .dma_n(dma_n));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rv = rdata;
      rr = rresp;
   endtask
   task automatic wt(input logic e);
      k = 0;
      while (irq !== e && k < 300) begin
         @(posedge aclk);
         k++;
      end
   endtask
   // The count is read only after the bus reads, so the request pulse has surely landed.
   task automatic done(input logic rg);
      wt(1'b1);
      chk(irq, 32'h1);
      if (rg) begin
         rd(adcc_pkg::OFS_DAT);
         chk(rv, 32'(q.pop_front()));
         chk(32'(dma_n), 32'(nd));
      end
      rd(adcc_pkg::OFS_STS);
      chk(rv, rg ? 32'h0000_0032 : 32'h0000_004E);
      wr(adcc_pkg::OFS_STS, 32'h0);
      wt(1'b0);
      chk(irq, 32'h0);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      repeat (30000) @(posedge aclk);
      num_errors++;
      results();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go, inj, wde} = 9'h000;
      {awaddr, araddr, wdata, code} = 59'h0;
      wstrb = 4'hF;
      seed = 32'h0000_9137;
      smp = 12'h5A3;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(adcc_pkg::OFS_STS);
      chk(rv, 32'h0);
      rd(12'h100);
      chk(32'(rr), 32'(adcc_pkg::RESP_SLVERR));
      wr(adcc_pkg::OFS_CTRL1, 32'h0000_00A0);
      nd = 1;
      q.push_back(int'(smp));
      wr(adcc_pkg::OFS_CTRL2, 32'h0080_0101);
      // The power output is one flop behind the control bit, so let one edge pass.
      @(posedge aclk);
      chk(tpw, 32'h1);
      done(1'b1);
      // Regular codes first, then injected, so every selector code is exercised once on each trigger.
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         smp <= seed[11:0];
         code <= 3'(i);
         inj <= i > 7;
         c2 = i > 7 ? 32'h0080_8101 | (32'(i % 8) << 12) : 32'h0090_0101 | (32'(i) << 17);
         if (i % 8 == 7)
            c2 |= i > 7 ? 32'h0020_0000 : 32'h0040_0000;
         if (i < 8) begin
            nd++;
            q.push_back(int'(seed[11:0]));
         end
         wr(adcc_pkg::OFS_CTRL2, c2);
         if (i % 8 != 7) begin
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
         end
         done(i < 8);
      end
      // A regular conversion on channel 17 is cut by an injected one on channel 3.
      // The regular one must then run again from scratch and end normally.
      inj <= 1'b0;
      code <= 3'h0;
      nd++;
      q.push_back(int'(smp));
      wr(adcc_pkg::OFS_CHSEL, 32'h0000_0311);
      wr(adcc_pkg::OFS_SAMPT1, 32'h00E0_0000);
      wr(adcc_pkg::OFS_CTRL2, 32'h0090_8101);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
      inj <= 1'b1;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(ch, 32'h3);
      chk(busy, 32'h1);
      repeat (100) @(posedge aclk);
      chk(ch, 32'h11);
      chk(busy, 32'h0);
      rd(adcc_pkg::OFS_DAT);
      chk(rv, 32'(q.pop_front()));
      chk(32'(dma_n), 32'(nd));
      rd(adcc_pkg::OFS_STS);
      chk(rv, 32'h0000_007E);
      wr(adcc_pkg::OFS_STS, 32'h0);
      wde <= 1'b1;
      @(posedge aclk);
      wde <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(irq, 32'h0);
      rd(adcc_pkg::OFS_STS);
      chk(rv, 32'h1);
      wr(adcc_pkg::OFS_STS, 32'h0);
      wr(adcc_pkg::OFS_CTRL1, 32'h0000_0040);
      wde <= 1'b1;
      @(posedge aclk);
      wde <= 1'b0;
      wt(1'b1);
      chk(irq, 32'h1);
      wr(adcc_pkg::OFS_CTRL2, 32'h0000_0101);
      @(posedge aclk);
      chk(tpw, 32'h0);
      results();
   end
endmodule
